// ### pmbus_smbus_slave_port.sv
`timescale 1ns/100ps
// How it works
// [R1] straps sampled once after reset pick address
// [R2] factory address also acknowledged
// [R3] bytes shifted most significant bit first
// [R4] group write executes only at stop
// [R5] outside alerting only own or factory address acked, never general call
// [R6] while alerting only alert response address acked
// [R7] send own address, release alert on win
// [R8] start or stop mid-byte: data fault
// [R9] too few bytes dropped silently
// [R10] too many written bytes: data fault
// [R11] read past length returns ones, data fault
// [R12] read before command code: ones, data fault
// [R13] unsupported or wrong-page command: command fault
// [R14] invalid page, operation, protect data rejected
// [R15] read of write-only command: ones, data fault
// [R16] write to read-only command: command fault
// [R17] scl low timeout resets port, no flags
// [R18] host sends one command per target per group
// [R19] page selects channel for later commands
// [R20] words travel low byte first
// [R21] parametric values are two-byte direct words
// [R22] alert raised only when enabled; once raised it stays driven even if enable then drops
// [R23] fault flags sticky until clear command or reset
module pmbus_smbus_slave_port
   import pmbus_port_pkg::*;
#(
   parameter int unsigned TMO_CYC = BUS_TIMEOUT_LIMIT_CYC
) (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   // serial bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic             alert_o,
   output logic             alert_oe_o,
   // address straps
   input  wire logic        addr_strap_lo_i,
   input  wire logic        addr_strap_hi_i,
   // configuration and device side
   input  wire logic        vendor_mode_config_alert_en_i,
   input  wire logic        fault_event_i,
   input  wire logic [15:0] rd_data_i,
   // status
   output logic [6:0]       own_addr_o,
   output logic [7:0]       page_o,
   output logic             cml_flag_o,
   output logic [7:0]       status_cml_o,
   // command execution
   output logic             exec_valid_o,
   output logic [7:0]       exec_code_o,
   output logic [15:0]      exec_data_o,
   output logic [7:0]       exec_page_o
);
   localparam int unsigned TW = $clog2(TMO_CYC + 1);

   typedef struct packed {
      port_state_t st;
      logic [3:0]  bitc;
      logic [7:0]  sh;
      logic        scl_d;
      logic        sda_d;
      logic        ack;
      logic        drv;
      logic        rw;
      logic        act;
      logic        ara;
      logic        bad;
      logic        rbad;
      logic        over;
      logic [2:0]  nb;
      logic [2:0]  rdi;
      logic [7:0]  cmd;
      logic [15:0] dat;
      logic [7:0]  page;
      logic        alert;
      logic        cml_b;
      logic        cml_cmd;
      logic        cml_dat;
      logic [6:0]  own;
      logic        strapped;
      logic [1:0]  scnt;
      logic [TW-1:0] tmo;
      logic        exv;
      logic [7:0]  exc;
      logic [15:0] exd;
      logic [7:0]  exp;
      logic        zero;
   } regs_t;

   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic [3:0]  pin_s;
   logic        scl_s, sda_s, lo_s, hi_s;
   logic        scl_rise, scl_fall, start_ev, stop_ev;
   logic        partial, tmo_hit, alerting;
   logic        set_cmd, set_dat, clr_flt;
   logic [7:0]  sh_in, tx_byte, stat_byte;
   logic [15:0] rd_word;
   cmd_attr_t   at, an;
   regs_t       q, d;

   // reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // pin synchronisers
   bit_sync #(.W(4)) u_pin_sync (
      .clk_i   (ref_clk_i),
      .rst_b_i (rst_n),
      .d_i     ({addr_strap_hi_i, addr_strap_lo_i, sda_i, scl_i}),
      .q_o     (pin_s)
   );
   assign scl_s = pin_s[0];
   assign sda_s = pin_s[1];
   assign lo_s  = pin_s[2];
   assign hi_s  = pin_s[3];

   // bus events from synchronised levels
   assign scl_rise = scl_s & ~q.scl_d;
   assign scl_fall = ~scl_s & q.scl_d;
   assign start_ev = scl_s & q.scl_d & q.sda_d & ~sda_s;
   assign stop_ev  = scl_s & q.scl_d & ~q.sda_d & sda_s;
   // [R8] unfinished byte at start or stop
   assign partial  = (start_ev | stop_ev) & ((q.st == S_WR) | (q.st == S_RD)) &
                     (q.bitc > 4'd1) & (q.bitc < 4'd8); // lone rise precedes sr or p
   // [R17] scl held low too long
   assign tmo_hit  = ~scl_s & (q.st != S_IDLE) & (q.tmo == TW'(TMO_CYC - 1));
   assign alerting = q.alert & vendor_mode_config_alert_en_i;
   assign sh_in    = {q.sh[6:0], sda_s};
   assign at       = cmd_lookup(q.cmd);
   assign an       = cmd_lookup(sh_in);
   assign stat_byte = 8'(q.cml_b) << STAT_CML_BIT;

   // [R21] read word source, two-byte words
   always_comb
   begin
      unique case (q.cmd)
         CMD_PAGE:      rd_word = {8'h00, q.page};
         CMD_STAT_BYTE: rd_word = {8'h00, stat_byte};
         CMD_STAT_WORD: rd_word = {8'h00, stat_byte};
         CMD_STAT_CML:  rd_word = {8'h00, q.cml_cmd, q.cml_dat, 6'h00};
         default:       rd_word = rd_data_i;
      endcase
   end

   // [R20] low byte first, ones past the end
   always_comb
   begin
      if (q.rbad || ({1'b0, q.rdi} >= {2'b00, at.len}))
         tx_byte = FILL_BYTE;
      else if (q.rdi == 3'd0)
         tx_byte = rd_word[7:0];
      else
         tx_byte = rd_word[15:8];
   end

   // next-state logic
   always_comb
   begin
      d = q;
      set_cmd = 1'b0;
      set_dat = 1'b0;
      clr_flt = 1'b0;
      d.scl_d = scl_s;
      d.sda_d = sda_s;
      d.exv   = 1'b0;
      d.tmo   = (~scl_s & (q.st != S_IDLE)) ? q.tmo + TW'(1) : '0;
      // [R1] capture straps once
      if (!q.strapped)
      begin
         d.scnt = q.scnt + 2'd1;
         if (q.scnt == STRAP_SETTLE_CYC)
         begin
            d.strapped = 1'b1;
            d.own      = STRAP_ADDR_BASE + {5'b00000, hi_s, lo_s};
         end
      end
      if (partial)
      begin
         set_dat = 1'b1;
         d.bad   = 1'b1;
      end
      if (start_ev)
      begin
         d.st   = S_ADDR;
         d.bitc = 4'd0;
         d.drv  = 1'b0;
      end
      else if (stop_ev)
      begin
         // [R4] [R9] deferred write, exact byte count only
         if (q.act && !q.rw && !q.bad && !partial && (q.nb == {1'b0, at.len} + 3'd1))
         begin
            // [R14] validate data
            if (!data_ok(q.cmd, q.dat[7:0]))
               set_dat = 1'b1;
            else
            begin
               d.exv = 1'b1;
               d.exc = q.cmd;
               d.exd = q.dat;
               d.exp = q.page;
               // [R19] page select
               if (q.cmd == CMD_PAGE)
                  d.page = q.dat[7:0];
               if (q.cmd == CMD_CLR_FAULTS)
                  clr_flt = 1'b1;
            end
         end
         d.st   = S_IDLE;
         d.act  = 1'b0;
         d.nb   = 3'd0;
         d.drv  = 1'b0;
         d.bitc = 4'd0;
      end
      else if (tmo_hit)
      begin
         d.st   = S_IDLE;
         d.act  = 1'b0;
         d.nb   = 3'd0;
         d.drv  = 1'b0;
         d.bitc = 4'd0;
      end
      else if (scl_rise)
      begin
         unique case (q.st)
            S_ADDR, S_WR:
            begin
               // [R3] shift in msb first
               if (q.bitc < 4'd8)
               begin
                  d.sh   = sh_in;
                  d.bitc = q.bitc + 4'd1;
               end
               if ((q.bitc == 4'd7) && (q.st == S_ADDR))
               begin
                  d.ack = 1'b0;
                  d.ara = 1'b0;
                  // [R6] only alert response address
                  if (alerting)
                  begin
                     d.ack = (sh_in[7:1] == ARA_ADDR) & sh_in[0];
                     d.ara = d.ack;
                  end
                  // [R2] own or factory address, [R5] no general call
                  else if ((sh_in[7:1] == q.own) || (sh_in[7:1] == FACTORY_ADDR))
                  begin
                     d.ack = 1'b1;
                     d.rw  = sh_in[0];
                     d.act = 1'b1;
                     d.rdi = 3'd0;
                     d.over = 1'b0;
                     d.rbad = 1'b0;
                     if (!sh_in[0])
                     begin
                        d.nb  = 3'd0;
                        d.bad = 1'b0;
                     end
                     // [R12] read where command expected
                     else if (q.nb == 3'd0)
                     begin
                        d.rbad  = 1'b1;
                        set_dat = 1'b1;
                     end
                     // [R15] read of write-only command
                     else if (at.ok && !at.rd && !q.bad)
                     begin
                        d.rbad  = 1'b1;
                        d.bad   = 1'b1;
                        set_dat = 1'b1;
                     end
                     else if (q.bad)
                        d.rbad = 1'b1;
                  end
               end
               else if ((q.bitc == 4'd7) && (q.nb == 3'd0))
               begin
                  d.ack = 1'b1;
                  d.cmd = sh_in;
                  d.nb  = 3'd1;
                  // [R13] unsupported or wrong page
                  if (!an.ok || (an.chan && (q.page > PAGE_CHAN_MAX)))
                  begin
                     d.bad   = 1'b1;
                     set_cmd = 1'b1;
                  end
               end
               else if (q.bitc == 4'd7)
               begin
                  d.ack = 1'b1;
                  d.nb  = (q.nb == 3'd7) ? q.nb : q.nb + 3'd1;
                  if (q.bad)
                     d.bad = 1'b1;
                  // [R16] write to read-only command
                  else if (!at.wr)
                  begin
                     d.bad   = 1'b1;
                     set_cmd = 1'b1;
                  end
                  // [R10] too many bytes written
                  else if (q.nb > {1'b0, at.len})
                  begin
                     d.bad   = 1'b1;
                     set_dat = 1'b1;
                  end
                  else if (q.nb == 3'd1)
                     d.dat[7:0] = sh_in;
                  else
                     d.dat[15:8] = sh_in;
               end
            end
            S_RD, S_ARA:
            begin
               if (q.bitc < 4'd8)
               begin
                  d.bitc = q.bitc + 4'd1;
                  // [R7] lost arbitration keeps alert
                  if ((q.st == S_ARA) && !q.drv && !sda_s)
                  begin
                     d.st   = S_IDLE;
                     d.bitc = 4'd0;
                  end
                  // [R7] won arbitration releases alert
                  else if ((q.st == S_ARA) && (q.bitc == 4'd7))
                     d.alert = 1'b0;
               end
               else if ((q.bitc == 4'd8) && !sda_s && (q.st == S_RD))
               begin
                  d.bitc = 4'd9;
                  d.rdi  = (q.rdi == 3'd7) ? q.rdi : q.rdi + 3'd1;
               end
               else
                  d.st = S_IDLE;
            end
            default: ;
         endcase
      end
      else if (scl_fall)
      begin
         unique case (q.st)
            S_ADDR, S_WR:
            begin
               if (q.bitc == 4'd8)
               begin
                  if (q.ack)
                  begin
                     d.drv  = 1'b1;
                     d.bitc = 4'd9;
                  end
                  else
                     d.st = S_IDLE;
               end
               else if (q.bitc == 4'd9)
               begin
                  d.bitc = 4'd0;
                  d.drv  = 1'b0;
                  if ((q.st == S_ADDR) && q.ara)
                  begin
                     d.st  = S_ARA;
                     d.sh  = {q.own, 1'b1};
                     d.drv = ~q.own[6];
                  end
                  else if ((q.st == S_ADDR) && q.rw)
                  begin
                     d.st  = S_RD;
                     d.sh  = tx_byte;
                     d.drv = ~tx_byte[7];
                  end
                  else
                     d.st = S_WR;
               end
            end
            S_RD, S_ARA:
            begin
               // [R3] shift out msb first
               if ((q.bitc != 4'd0) && (q.bitc < 4'd8))
               begin
                  d.sh  = {q.sh[6:0], 1'b0};
                  d.drv = ~q.sh[6];
               end
               else if (q.bitc == 4'd8)
                  d.drv = 1'b0;
               else if (q.bitc == 4'd9)
               begin
                  d.bitc = 4'd0;
                  d.sh   = tx_byte;
                  d.drv  = ~tx_byte[7];
                  // [R11] first byte past length
                  if (!q.rbad && !q.over && (tx_byte == FILL_BYTE) &&
                      ({1'b0, q.rdi} >= {2'b00, at.len}))
                  begin
                     d.over  = 1'b1;
                     set_dat = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      // [R23] sticky flags, set beats clear
      d.cml_b   = (q.cml_b & ~clr_flt) | set_cmd | set_dat;
      d.cml_cmd = (q.cml_cmd & ~clr_flt) | set_cmd;
      d.cml_dat = (q.cml_dat & ~clr_flt) | set_dat;
      // [R22] alert only when enabled
      if ((set_cmd | set_dat | fault_event_i) & vendor_mode_config_alert_en_i)
         d.alert = 1'b1;
      d.zero = 1'b0;
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   // outputs straight from state
   assign sda_o        = q.zero;
   assign sda_oe_o     = q.drv;
   assign alert_o      = q.zero;
   assign alert_oe_o   = q.alert;
   assign own_addr_o   = q.own;
   assign page_o       = q.page;
   assign cml_flag_o   = q.cml_b;
   assign status_cml_o = {q.cml_cmd, q.cml_dat, 6'h00};
   assign exec_valid_o = q.exv;
   assign exec_code_o  = q.exc;
   assign exec_data_o  = q.exd;
   assign exec_page_o  = q.exp;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_addr_done;
      scl_rise && (q.st == S_ADDR) && (q.bitc == 4'd7) && !start_ev && !stop_ev && !tmo_hit;
   endsequence
   sequence s_ara_last;
      scl_rise && (q.st == S_ARA) && (q.bitc == 4'd7) && (q.drv || sda_s) && !start_ev &&
      !stop_ev && !tmo_hit;
   endsequence

   property p_strap;
      $rose(q.strapped) |-> (q.own == STRAP_ADDR_BASE + {5'b00000, $past(hi_s), $past(lo_s)});
   endproperty
   a_strap: assert property (p_strap) else $error("strap address wrong"); // [R1]

   property p_no_gencall;
      s_addr_done and (sh_in[7:1] == 7'h00) |=> !q.ack;
   endproperty
   a_no_gencall: assert property (p_no_gencall) else $error("general call acked"); // [R5]

   property p_ara_only;
      s_addr_done and alerting and (sh_in[7:1] != ARA_ADDR) |=> !q.ack;
   endproperty
   a_ara_only: assert property (p_ara_only) else $error("acked while alerting"); // [R6]

   property p_ara_release;
      s_ara_last |=> !alert_oe_o;
   endproperty
   a_ara_release: assert property (p_ara_release) else $error("alert kept after win"); // [R7]

   property p_partial;
      partial |=> (q.cml_dat && q.cml_b) ##1 (q.cml_dat || $past(clr_flt));
   endproperty
   a_partial: assert property (p_partial) else $error("partial byte not flagged"); // [R8]

   property p_timeout;
      tmo_hit && !start_ev && !stop_ev |=> (q.st == S_IDLE) && !sda_oe_o && !$changed(q.cml_b);
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout not handled"); // [R17]

   property p_alert_gate;
      $rose(alert_oe_o) |-> $past(vendor_mode_config_alert_en_i);
   endproperty
   a_alert_gate: assert property (p_alert_gate) else $error("alert while disabled"); // [R22]

   property p_sticky;
      q.cml_b && !clr_flt |=> q.cml_b;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost"); // [R23]

   property p_exec_stop;
      $rose(exec_valid_o) |-> $past(stop_ev) ##1 !exec_valid_o;
   endproperty
   a_exec_stop: assert property (p_exec_stop) else $error("execute not at stop"); // [R4]

   property p_page_sel;
      exec_valid_o && (exec_code_o == CMD_PAGE) |-> (page_o == exec_data_o[7:0]);
   endproperty
   a_page_sel: assert property (p_page_sel) else $error("page not taken"); // [R19]

endmodule // pmbus_smbus_slave_port

// ### pmbus_port_pkg.sv
package pmbus_port_pkg;

   // clock and bus timing
   localparam int unsigned CLK_MHZ               = 100;
   localparam int unsigned BUS_TIMEOUT_LIMIT_US  = 25_000;
   localparam int unsigned BUS_TIMEOUT_LIMIT_CYC = BUS_TIMEOUT_LIMIT_US * CLK_MHZ;
   localparam logic [1:0]  STRAP_SETTLE_CYC      = 2'h3;

   // 7-bit slave addresses
   localparam logic [6:0] STRAP_ADDR_BASE = 7'h6a;
   localparam logic [6:0] FACTORY_ADDR    = 7'h1a;
   localparam logic [6:0] ARA_ADDR        = 7'h0c;

   // command codes
   localparam logic [7:0] CMD_PAGE        = 8'h00;
   localparam logic [7:0] CMD_OPERATION   = 8'h01;
   localparam logic [7:0] CMD_CLR_FAULTS  = 8'h03;
   localparam logic [7:0] CMD_WR_PROTECT  = 8'h10;
   localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
   localparam logic [7:0] CMD_STAT_BYTE   = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD   = 8'h79;
   localparam logic [7:0] CMD_STAT_CML    = 8'h7e;
   localparam logic [7:0] CMD_READ_VOUT   = 8'h8b;
   localparam logic [7:0] CMD_VENDOR_MODE = 8'hd1;

   // page limits
   localparam logic [7:0] PAGE_CHAN_MAX = 8'h05;
   localparam logic [7:0] PAGE_MAX      = 8'h0d;
   localparam logic [7:0] PAGE_ALL      = 8'hff;

   // status bit positions
   localparam int unsigned STAT_CML_BIT  = 1;
   localparam int unsigned CML_CMD_BIT   = 7;
   localparam int unsigned CML_DATA_BIT  = 6;
   localparam logic [7:0]  FILL_BYTE     = 8'hff;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WR, S_RD, S_ARA} port_state_t;

   typedef struct packed {
      logic       ok;    // supported
      logic       rd;    // readable
      logic       wr;    // writable
      logic [1:0] len;   // data bytes
      logic       chan;  // valid on channel pages only
   } cmd_attr_t;

   // supported command set
   function automatic cmd_attr_t cmd_lookup(input logic [7:0] code);
      cmd_attr_t a;
      a = '0;
      unique case (code)
         CMD_PAGE, CMD_OPERATION, CMD_WR_PROTECT: a = '{1'b1, 1'b1, 1'b1, 2'd1, 1'b0};
         CMD_CLR_FAULTS, CMD_STORE_ALL, CMD_RESTORE_ALL:
            a = '{1'b1, 1'b0, 1'b1, 2'd0, 1'b0};
         CMD_STAT_BYTE, CMD_STAT_CML: a = '{1'b1, 1'b1, 1'b0, 2'd1, 1'b0};
         CMD_STAT_WORD:   a = '{1'b1, 1'b1, 1'b0, 2'd2, 1'b0};
         CMD_READ_VOUT:   a = '{1'b1, 1'b1, 1'b0, 2'd2, 1'b1};
         CMD_VENDOR_MODE: a = '{1'b1, 1'b1, 1'b1, 2'd2, 1'b0};
         default:         a = '0;
      endcase
      return a;
   endfunction

   // data checks for the validated commands
   function automatic logic data_ok(input logic [7:0] code, input logic [7:0] v);
      logic ok;
      ok = 1'b1;
      if (code == CMD_PAGE)
         ok = (v <= PAGE_MAX) || (v == PAGE_ALL);
      else if (code == CMD_OPERATION)
         ok = (v == 8'h00) || (v == 8'h40) || (v == 8'h80);
      else if (code == CMD_WR_PROTECT)
         ok = (v == 8'h00) || (v == 8'h20) || (v == 8'h40) || (v == 8'h80);
      return ok;
   endfunction

endpackage

// ### bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;

   // two-stage synchroniser, first stage read only by second
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_ff <= '0;
         q_o     <= '0;
      end
      else
      begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end
endmodule // bit_sync

// ### smbus_host_model.sv
`timescale 1ns/100ps
module smbus_host_model (
   // clock
   input  wire logic clk_i,
   // device pull-down enable
   input  wire logic sda_oe_i,
   // host lines, released high
   output logic      scl_o = 1'b1,
   output logic      sda_o = 1'b1
);
   // wait system clocks
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // data moves, then clock moves, 4 clocks apart
   task automatic step(input logic d, input logic c);
      wt(4);
      sda_o <= d;
      wt(4);
      scl_o <= c;
   endtask
   // start or repeated start, scl stands high between frames
   task automatic start();
      step(1'b1, 1'b1);
      step(1'b0, 1'b0);
   endtask
   // stop, both lines released
   task automatic stop();
      step(1'b0, 1'b1);
      wt(4);
      sda_o <= 1'b1;
      wt(8);
   endtask
   // one bit, wired level read mid-high
   task automatic bit_x(input logic b, output logic r);
      step(b, 1'b1);
      wt(4);
      r = sda_o & ~sda_oe_i;
      wt(4);
      scl_o <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(a, k);
   endtask
endmodule // smbus_host_model

// ### pmbus_smbus_slave_port_tb.sv
`timescale 1ns/100ps
module pmbus_smbus_slave_port_tb;
   import pmbus_port_pkg::*;
   localparam int unsigned TMO = 200;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        lo = 1'b0;
   logic        hi = 1'b0;
   logic        aen = 1'b0;
   logic        flt = 1'b0;
   logic [15:0] rdw = 16'h0000;
   logic        scl, sdh, sda_oe, alert_oe, cml, exv, ak, k, sdo, alo;
   logic [6:0]  own, own_q;
   logic [7:0]  page, stat, code, epg, q, p;
   logic [15:0] data, v, w;
   int          seed = 68313;
   int          miscompares = 0;
   int          num_checks = 0;
   int          n_exec = 0;
   int          cycles = 0;
   int          m;

   pmbus_smbus_slave_port #(.TMO_CYC(TMO)) DUT (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sdh & ~sda_oe),
      .sda_o(sdo), .sda_oe_o(sda_oe), .alert_o(alo), .alert_oe_o(alert_oe),
      .addr_strap_lo_i(lo), .addr_strap_hi_i(hi), .vendor_mode_config_alert_en_i(aen),
      .fault_event_i(flt), .rd_data_i(rdw), .own_addr_o(own_q), .page_o(page),
      .cml_flag_o(cml), .status_cml_o(stat), .exec_valid_o(exv), .exec_code_o(code),
      .exec_data_o(data), .exec_page_o(epg));
   smbus_host_model h (.clk_i(ref_clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sdh));

   // 100 MHz clock
   initial forever #5 ref_clk_i = ~ref_clk_i;

   // exec pulse count and hang guard
   always @(posedge ref_clk_i)
   begin
      n_exec <= n_exec + ((exv === 1'b1) ? 1 : 0);
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   // write transfer, address ack kept
   task automatic wr(input logic [6:0] a, input logic [7:0] b[$]);
      h.start();
      h.xfer({a, 1'b0}, 1'b1, q, ak);
      foreach (b[i])
         h.xfer(b[i], 1'b1, q, k);
      h.stop();
   endtask

   // status check, then flags cleared
   task automatic fl(input string n, input logic [7:0] e);
      chk(n, 16'(e), 16'(stat));
      wr(own, '{CMD_CLR_FAULTS});
   endtask

   // command, repeated start, n bytes read, last one refused
   task automatic rd(input logic [7:0] c, input int n);
      v = '1;
      h.start();
      h.xfer({own, 1'b0}, 1'b1, q, k);
      h.xfer(c, 1'b1, q, k);
      h.start();
      h.xfer({own, 1'b1}, 1'b1, q, ak);
      for (int i = 0; i < n; i++)
      begin
         h.xfer(8'hff, 1'(i == n - 1), q, k);
         v[8*i+:8] = q;
      end
      h.stop();
   endtask

   // alert response read with host arbitration byte
   task automatic ara(input logic [7:0] d);
      h.start();
      h.xfer({ARA_ADDR, 1'b1}, 1'b1, q, ak);
      h.xfer(d, 1'b1, q, k);
      h.stop();
   endtask

   // main sequence
   initial
   begin
      {hi, lo} <= 2'($random(seed));
      rdw <= 16'($random(seed));
      repeat (10) @(posedge ref_clk_i);
      own = STRAP_ADDR_BASE + 7'({hi, lo});
      rst_b_i <= 1'b1;
      h.wt(30);
      chk("own_addr", 16'(own), 16'(own_q));
      wr(own, '{CMD_PAGE, 8'h02});
      chk("ack_page", 16'h0002, {ak, page});
      chk("exec_code", 16'(CMD_PAGE), 16'(code));
      w = 16'($random(seed));
      wr(own, '{CMD_VENDOR_MODE, w[7:0], w[15:8]});
      chk("exec_word", w, data);
      chk("exec_page", 16'h0002, 16'(epg));
      wr(7'h00, '{CMD_PAGE, 8'h01});
      chk("gencall", 16'h0102, {ak, page});
      wr(FACTORY_ADDR, '{CMD_PAGE, 8'h03});
      chk("factory", 16'h0003, {ak, page});
      repeat (4)
      begin
         p = 8'($unsigned($random(seed)) % 6);
         wr(own, '{CMD_PAGE, p});
         chk("page_rand", 16'(p), 16'(page));
      end
      rd(CMD_READ_VOUT, 2);
      chk("read_word", rdw, v);
      m = n_exec;
      wr(own, '{CMD_VENDOR_MODE, 8'h55});
      chk("short", 16'(m), 16'(n_exec));
      chk("short_stat", 0, 16'(stat));
      wr(own, '{8'h20});
      chk("unsup", 16'h0180, {cml, stat});
      rd(CMD_STAT_CML, 2);
      chk("over_read", 16'hff80, v);
      fl("over_read_stat", 8'hc0);
      chk("cleared", 0, {cml, stat});
      wr(own, '{CMD_STAT_BYTE, 8'h00});
      fl("ro_write", 8'h80);
      wr(own, '{CMD_PAGE, 8'h01, 8'h01});
      chk("over_write_page", 16'(p), 16'(page));
      fl("over_write", 8'h40);
      h.start();
      h.xfer({own, 1'b0}, 1'b1, q, k);
      repeat (3) h.bit_x(1'b0, k);
      h.stop();
      fl("mid_byte", 8'h40);
      h.start();
      h.xfer({own, 1'b1}, 1'b1, q, ak);
      h.xfer(8'hff, 1'b1, q, k);
      h.stop();
      chk("early_read", 16'h00ff, {ak, q});
      fl("early_stat", 8'h40);
      m = n_exec;
      rd(CMD_CLR_FAULTS, 1);
      chk("wo_read", 16'h00ff, {ak, v[7:0]});
      chk("wo_exec", 16'(m), 16'(n_exec));
      fl("wo_stat", 8'h40);
      h.start();
      h.xfer({own, 1'b0}, 1'b1, q, k);
      h.xfer(CMD_PAGE, 1'b1, q, k);
      h.xfer(8'h01, 1'b1, q, k);
      h.wt(40);
      chk("group_hold", 16'(p), 16'(page));
      h.start();
      h.xfer({7'h2b, 1'b0}, 1'b1, q, k);
      h.xfer(CMD_PAGE, 1'b1, q, k);
      h.stop();
      chk("group_exec", 16'h0001, 16'(page));
      h.start();
      h.xfer({own, 1'b0}, 1'b1, q, ak);
      h.wt(TMO + 50);
      chk("timeout", 0, {sda_oe, cml, stat});
      h.stop();
      flt <= 1'b1;
      h.wt(1);
      flt <= 1'b0;
      h.wt(5);
      chk("alert_off", 0, 16'(alert_oe));
      aen <= 1'b1;
      wr(own, '{CMD_PAGE, 8'h0e});
      chk("bad_page", 16'h0101, {alert_oe, page});
      chk("bad_stat", 16'h0040, 16'(stat));
      chk("od_low", 0, {sdo, alo});
      wr(own, '{CMD_PAGE, 8'h02});
      chk("alerting", 16'h0101, {ak, page});
      ara(8'h00);
      chk("ara_lost", 16'h0001, {ak, alert_oe});
      ara(8'hff);
      chk("ara_won", {8'h00, own, 1'b1}, {ak, alert_oe, q});
      wr(own, '{CMD_PAGE, 8'h02});
      chk("resumed", 16'h0002, {ak, page});
      complete_run();
   end
endmodule // pmbus_smbus_slave_port_tb
